// File: core/bit_sync.sv
// two flip-flop synchroniser for a bundle of levels or a gray vector
`timescale 1ns/1ps
module bit_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	input  wire logic         en_i,
	// levels
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta_r;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_r <= '0;
			q_o    <= '0;
		end else if (en_i) begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end

endmodule // bit_sync

// File: core/dual_clock_fifo_status_flags.sv
// dual clock buffer with full, empty and almost-full status flags
//
// Summary of operation
// R1 - standard: full flag low when full, blocks writes
// R2 - standard full after base depth writes
// R3 - fall-through: input-ready low while room exists
// R4 - input-ready counts the output register word
// R5 - full flag on write clock, two stages
// R6 - retransmit compares write pointer to mark
// R7 - standard: empty flag low when empty, blocks reads
// R8 - output-ready low as first word appears
// R9 - output-ready rises only on a true read or a retransmit
// R10 - last word held, later reads ignored
// R11 - empty two stages, output-ready one stage
// R12 - almost-full low after depth minus offset writes
// R13 - fall-through almost-full one write later
// R14 - async almost-full: set write, release read
// R15 - sync almost-full updates on write edges only
// R16 - timing select sampled during master reset
// R17 - read select gates the fall-through load only when a word is held
// R18 - blocked accesses change no data or pointers
// R19 - both resets clear pointers and flags
`timescale 1ns/1ps
module dual_clock_fifo_status_flags (
	// write clock domain
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	input  wire logic        ce_i,
	// read clock domain
	input  wire logic        rd_clk_i,
	// configuration and reset pins
	input  wire logic        master_reset_n_i,
	input  wire logic        partial_reset_n_i,
	input  wire logic        flag_timing_select_i,
	input  wire logic        fall_through_mode_i,
	input  wire logic        narrow_ports_i,
	input  wire logic [12:0] full_offset_i,
	// write port
	input  wire logic        wr_en_n_i,
	input  wire logic [17:0] wr_data_i,
	// read port
	input  wire logic        rd_en_n_i,
	input  wire logic        read_select_n_i,
	input  wire logic        mark_i,
	input  wire logic        replay_i,
	output logic      [17:0] rd_data_o,
	// status flags
	output logic             storage_full_n_o,
	output logic             write_room_n_o,
	output logic             near_full_n_o,
	output logic             storage_empty_n_o,
	output logic             out_ready_n_o
);

	// storage shared by both domains, written only on mclk_i
	logic [17:0] mem [4096];

	// ---------------- write clock domain ----------------
	logic [4:0]  pin_w;
	logic        timing_sync_r;
	logic        fall_through_mode_w_r;
	logic        narrow_r;
	logic [12:0] wacc_r;
	logic [12:0] wacc_nxt;
	logic [12:0] mem_wa_r;
	logic [12:0] mem_wa_nxt;
	logic [12:0] memw_g_r;
	logic [12:0] rcons_g_w;
	logic [12:0] rcons_prev_r;
	logic        mark_on_w;
	logic        mark_hold_r;
	logic [12:0] mark_ptr_w_r;
	logic        full_s1_r;
	logic        near_s1_r;
	logic        near_pin_nxt;
	logic        stg_in_ready;
	logic        stg_out_valid;
	logic [17:0] stg_out_data;

	// read-domain registers seen by the write side
	logic [12:0] rcons_g_r;
	logic        mark_on_r;
	logic [12:0] mark_ptr_r;

	bit_sync #(.W(5)) u_pin_w (
		.clk_i   (mclk_i),
		.rst_b_i (rst_b_i),
		.en_i    (ce_i),
		.d_i     ({master_reset_n_i, partial_reset_n_i,
		           flag_timing_select_i, fall_through_mode_i,
		           narrow_ports_i}),
		.q_o     (pin_w)
	);

	wire mrs_w_n = pin_w[4];
	wire clr_w   = !pin_w[4] || !pin_w[3];

	bit_sync #(.W(13)) u_rcons_sync (
		.clk_i   (mclk_i),
		.rst_b_i (rst_b_i),
		.en_i    (ce_i),
		.d_i     (rcons_g_r),
		.q_o     (rcons_g_w)
	);

	bit_sync #(.W(1)) u_mark_sync (
		.clk_i   (mclk_i),
		.rst_b_i (rst_b_i),
		.en_i    (ce_i),
		.d_i     (mark_on_r),
		.q_o     (mark_on_w)
	);

	wire [12:0] rcons_w = fifo_flag_pkg::gray2bin(rcons_g_w);
	wire [12:0] depth_w = narrow_r ? fifo_flag_pkg::DEPTH_NARROW
	                               : fifo_flag_pkg::DEPTH_WIDE;
	wire [12:0] cap_w   = depth_w + {12'h000, fall_through_mode_w_r}; // see R2 see R4
	wire [12:0] ref_w   = mark_hold_r ? mark_ptr_w_r
	                                  : rcons_w;      // see R6
	wire [12:0] used_w  = wacc_r - ref_w;
	wire        full_w  = (used_w >= cap_w);
	wire [12:0] near_at = cap_w - full_offset_i;      // see R12 see R13
	wire        near_w  = (used_w >= near_at);
	wire        rd_moved = (rcons_w != rcons_prev_r);
	wire        wr_try  = !wr_en_n_i && !full_w && !clr_w; // see R1 see R18
	wire        wr_take = wr_try && stg_in_ready;
	wire        drain   = stg_out_valid && !clr_w;

	stage_fifo #(
		.W     (fifo_flag_pkg::DATA_W),
		.DEPTH (fifo_flag_pkg::STAGE_DEPTH)
	) u_stage (
		.clk_i       (mclk_i),
		.rst_b_i     (rst_b_i),
		.en_i        (ce_i),
		.clr_i       (clr_w),
		.in_valid_i  (wr_try),
		.in_ready_o  (stg_in_ready),
		.in_data_i   (wr_data_i),
		.out_valid_o (stg_out_valid),
		.out_ready_i (!clr_w),
		.out_data_o  (stg_out_data)
	);

	assign wacc_nxt   = clr_w ? fifo_flag_pkg::PTR_RST :
	                    wr_take ? wacc_r + fifo_flag_pkg::PTR_ONE
	                            : wacc_r;            // see R19
	assign mem_wa_nxt = clr_w ? fifo_flag_pkg::PTR_RST :
	                    drain ? mem_wa_r + fifo_flag_pkg::PTR_ONE
	                          : mem_wa_r;

	// sync mode follows the staged count; async sets now, clears on reads
	always_comb begin
		near_pin_nxt = near_full_n_o;
		if (clr_w) begin
			near_pin_nxt = fifo_flag_pkg::FLAG_HI;
		end else if (timing_sync_r) begin
			near_pin_nxt = !near_s1_r;                // see R15
		end else if (near_w) begin
			near_pin_nxt = fifo_flag_pkg::FLAG_LO;    // see R14
		end else if (rd_moved) begin
			near_pin_nxt = fifo_flag_pkg::FLAG_HI;    // see R14
		end
	end

	// mode straps caught while master reset is held
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			timing_sync_r <= fifo_flag_pkg::FLAG_LO;
			fall_through_mode_w_r      <= fifo_flag_pkg::FLAG_LO;
			narrow_r      <= fifo_flag_pkg::FLAG_LO;
		end else if (ce_i && !mrs_w_n) begin
			timing_sync_r <= pin_w[2];                // see R16
			fall_through_mode_w_r      <= pin_w[1];
			narrow_r      <= pin_w[0];
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wacc_r       <= fifo_flag_pkg::PTR_RST;
			mem_wa_r     <= fifo_flag_pkg::PTR_RST;
			memw_g_r     <= fifo_flag_pkg::PTR_RST;
			rcons_prev_r <= fifo_flag_pkg::PTR_RST;
		end else if (ce_i) begin
			wacc_r       <= wacc_nxt;
			mem_wa_r     <= mem_wa_nxt;
			memw_g_r     <= fifo_flag_pkg::bin2gray(mem_wa_nxt);
			rcons_prev_r <= rcons_w;
		end
	end

	// mark pointer is stable for two cycles before the level arrives
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mark_hold_r  <= fifo_flag_pkg::FLAG_LO;
			mark_ptr_w_r <= fifo_flag_pkg::PTR_RST;
		end else if (ce_i) begin
			mark_hold_r <= mark_on_w && !clr_w;
			if (mark_on_w && !mark_hold_r) begin
				mark_ptr_w_r <= mark_ptr_r;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (ce_i && drain) begin
			mem[mem_wa_r[11:0]] <= stg_out_data;
		end
	end

	// two register stages to the full / input-ready pins
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			full_s1_r        <= fifo_flag_pkg::FLAG_LO;
			near_s1_r        <= fifo_flag_pkg::FLAG_LO;
			storage_full_n_o <= fifo_flag_pkg::FLAG_HI;
			write_room_n_o   <= fifo_flag_pkg::FLAG_HI;
			near_full_n_o    <= fifo_flag_pkg::FLAG_HI;
		end else if (ce_i) begin
			full_s1_r        <= full_w && !clr_w;        // see R5
			near_s1_r        <= near_w && !clr_w;
			storage_full_n_o <= fall_through_mode_w_r || !full_s1_r;   // see R1 see R5
			write_room_n_o   <= !fall_through_mode_w_r || full_s1_r;   // see R3 see R5
			near_full_n_o    <= near_pin_nxt;
		end
	end

	// ---------------- read clock domain ----------------
	logic [2:0]  pin_r;
	logic [12:0] memw_g_rd;
	logic [12:0] rptr_r;
	logic [12:0] rptr_nxt;
	logic [12:0] rcons_r;
	logic [12:0] rcons_nxt;
	logic        empty_s1_r;
	fifo_flag_pkg::hold_e hold_r;
	fifo_flag_pkg::hold_e hold_nxt;

	bit_sync #(.W(3)) u_pin_r (
		.clk_i   (rd_clk_i),
		.rst_b_i (rst_b_i),
		.en_i    (1'b1),
		.d_i     ({master_reset_n_i, partial_reset_n_i, fall_through_mode_w_r}),
		.q_o     (pin_r)
	);

	bit_sync #(.W(13)) u_wptr_sync (
		.clk_i   (rd_clk_i),
		.rst_b_i (rst_b_i),
		.en_i    (1'b1),
		.d_i     (memw_g_r),
		.q_o     (memw_g_rd)
	);

	wire        clr_r    = !pin_r[2] || !pin_r[1];
	wire        fall_through_mode_r   = pin_r[0];
	wire [12:0] wptr_r   = fifo_flag_pkg::gray2bin(memw_g_rd);
	wire        mem_has  = (wptr_r != rptr_r);
	wire        rd_req   = !rd_en_n_i && !read_select_n_i;
	wire        do_replay = replay_i && mark_on_r && !read_select_n_i;
	wire        holding  = (hold_r == fifo_flag_pkg::HOLD_FULL);
	wire        std_take = !fall_through_mode_r && rd_req && mem_has;  // see R7 see R18
	wire        pop      = fall_through_mode_r && rd_req && holding;   // see R10
	// fall-through load into an empty output word ignores read select
	wire        load     = fall_through_mode_r && mem_has &&
	                       (!holding || pop);             // see R8 see R17

	always_comb begin
		rptr_nxt  = rptr_r;
		rcons_nxt = rcons_r;
		hold_nxt  = hold_r;
		if (clr_r) begin
			rptr_nxt  = fifo_flag_pkg::PTR_RST;           // see R19
			rcons_nxt = fifo_flag_pkg::PTR_RST;
			hold_nxt  = fifo_flag_pkg::HOLD_EMPTY;
		end else if (do_replay) begin
			rptr_nxt  = mark_ptr_r;
			rcons_nxt = mark_ptr_r;
			hold_nxt  = fifo_flag_pkg::HOLD_EMPTY;
		end else begin
			if (std_take || load) begin
				rptr_nxt = rptr_r + fifo_flag_pkg::PTR_ONE;
			end
			if (std_take || pop) begin
				rcons_nxt = rcons_r + fifo_flag_pkg::PTR_ONE;
			end
			case (hold_r)
				fifo_flag_pkg::HOLD_EMPTY: begin
					if (load) begin
						hold_nxt = fifo_flag_pkg::HOLD_FULL;
					end
				end
				fifo_flag_pkg::HOLD_FULL: begin
					if (pop && !load) begin
						hold_nxt = fifo_flag_pkg::HOLD_EMPTY; // see R9
					end
				end
				default: begin
					hold_nxt = fifo_flag_pkg::HOLD_EMPTY;
				end
			endcase
		end
	end

	always_ff @(posedge rd_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rptr_r    <= fifo_flag_pkg::PTR_RST;
			rcons_r   <= fifo_flag_pkg::PTR_RST;
			rcons_g_r <= fifo_flag_pkg::PTR_RST;
			hold_r    <= fifo_flag_pkg::HOLD_EMPTY;
		end else begin
			rptr_r    <= rptr_nxt;
			rcons_r   <= rcons_nxt;
			rcons_g_r <= fifo_flag_pkg::bin2gray(rcons_nxt);
			hold_r    <= hold_nxt;
		end
	end

	// mark captures the consumed position on the rising level
	always_ff @(posedge rd_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mark_on_r  <= fifo_flag_pkg::FLAG_LO;
			mark_ptr_r <= fifo_flag_pkg::PTR_RST;
		end else begin
			mark_on_r <= mark_i && !clr_r;
			if (mark_i && !mark_on_r && !clr_r) begin
				mark_ptr_r <= rcons_r;
			end
		end
	end

	// data held when nothing is read, so the last word stays visible
	always_ff @(posedge rd_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_data_o <= fifo_flag_pkg::DATA_RST;
		end else if (std_take || load) begin
			rd_data_o <= mem[rptr_r[11:0]];              // see R10
		end
	end

	// empty: synchroniser, one stage, pin; ready: synchroniser, pin
	always_ff @(posedge rd_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			empty_s1_r        <= fifo_flag_pkg::FLAG_HI;
			storage_empty_n_o <= fifo_flag_pkg::FLAG_LO;
			out_ready_n_o     <= fifo_flag_pkg::FLAG_HI;
		end else begin
			empty_s1_r        <= !mem_has || clr_r;        // see R11
			storage_empty_n_o <= !fall_through_mode_r && !empty_s1_r;   // see R7 see R11
			out_ready_n_o     <= !fall_through_mode_r ||
			                     (hold_nxt !=
			                      fifo_flag_pkg::HOLD_FULL); // see R8 see R11
		end
	end

endmodule // dual_clock_fifo_status_flags

// File: core/fifo_flag_pkg.sv
// shared constants, types and pointer helpers for the dual clock buffer
package fifo_flag_pkg;

	localparam int          DATA_W      = 18;
	localparam int          PTR_W       = 13;
	localparam int          ADDR_W      = 12;
	localparam int          STAGE_DEPTH = 4;
	localparam logic [12:0] DEPTH_WIDE  = 13'h0800;
	localparam logic [12:0] DEPTH_NARROW = 13'h1000;
	localparam logic [12:0] PTR_RST     = 13'h0000;
	localparam logic [12:0] PTR_ONE     = 13'h0001;
	localparam logic [17:0] DATA_RST    = 18'h00000;
	localparam logic        FLAG_HI     = 1'b1;
	localparam logic        FLAG_LO     = 1'b0;

	typedef enum logic [1:0] {
		HOLD_EMPTY = 2'b01,
		HOLD_FULL  = 2'b10
	} hold_e;

	function automatic logic [12:0] bin2gray(input logic [12:0] b);
		bin2gray = b ^ (b >> 1);
	endfunction

	function automatic logic [12:0] gray2bin(input logic [12:0] g);
		logic [12:0] b;
		b = g;
		for (int i = 11; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		gray2bin = b;
	endfunction

endpackage

// File: core/stage_fifo.sv
// small valid/ready staging buffer with parameterised width and depth
`timescale 1ns/1ps
module stage_fifo #(
	parameter int W     = 18,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	input  wire logic         en_i,
	input  wire logic         clr_i,
	// fill side
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	// drain side
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic      [W-1:0] out_data_o
);

	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wp_r;
	logic [AW:0]  rp_r;
	wire          full_w  = (wp_r[AW] != rp_r[AW]) &&
	                        (wp_r[AW-1:0] == rp_r[AW-1:0]);
	wire          empty_w = (wp_r == rp_r);
	wire          push_w  = in_valid_i && !full_w;
	wire          pop_w   = out_ready_i && !empty_w;

	assign in_ready_o  = !full_w;
	assign out_valid_o = !empty_w;
	assign out_data_o  = mem[rp_r[AW-1:0]];

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wp_r <= '0;
			rp_r <= '0;
		end else if (en_i) begin
			if (clr_i) begin
				wp_r <= '0;
				rp_r <= '0;
			end else begin
				if (push_w) begin
					wp_r <= wp_r + 1'b1;
				end
				if (pop_w) begin
					rp_r <= rp_r + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (en_i && push_w && !clr_i) begin
			mem[wp_r[AW-1:0]] <= in_data_i;
		end
	end

endmodule // stage_fifo

// File: verif/dual_clock_fifo_status_flags_bench.sv
// self-checking bench for the dual clock buffer flags
`timescale 1ns/1ps
module dual_clock_fifo_status_flags_bench;
	localparam int M = 16;
	logic        mclk_i = 1'b0;
	logic        rd_clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        ce_i = 1'b1;
	logic        master_reset_n_i = 1'b1;
	logic        partial_reset_n_i = 1'b1;
	logic        flag_timing_select_i = 1'b1;
	logic        fall_through_mode_i = 1'b0;
	logic [12:0] full_offset_i = 13'h0010;
	logic        wr_en_n_i = 1'b1;
	logic [17:0] wr_data_i = 18'h00000;
	logic        rd_en_n_i;
	logic        read_select_n_i;
	logic        got;
	logic        load = 1'b0;
	logic [11:0] count = 12'h000;
	logic [17:0] rd_data_o;
	logic [17:0] got_data;
	logic [17:0] last_w = 18'h00000;
	logic [17:0] seed = 18'h00057;
	logic        storage_full_n_o;
	logic        write_room_n_o;
	logic        near_full_n_o;
	logic        storage_empty_n_o;
	logic        out_ready_n_o;
	int          fails = 0;
	int          compares = 0;
	int          cap = 2048;
	logic [17:0] q[$];
	wire  [17:0] flags = {13'h0000, storage_full_n_o, write_room_n_o,
		near_full_n_o, storage_empty_n_o, out_ready_n_o};

	dual_clock_fifo_status_flags dual_clock_fifo_status_flags_i (
		.mclk_i, .rst_b_i, .ce_i, .rd_clk_i, .master_reset_n_i,
		.partial_reset_n_i, .flag_timing_select_i, .fall_through_mode_i,
		.narrow_ports_i(1'b0), .full_offset_i, .wr_en_n_i, .wr_data_i,
		.rd_en_n_i, .read_select_n_i, .mark_i(1'b0), .replay_i(1'b0),
		.rd_data_o, .storage_full_n_o, .write_room_n_o, .near_full_n_o,
		.storage_empty_n_o, .out_ready_n_o);
	fifo_reader fifo_reader_i (
		.rd_clk_i, .rst_b_i, .load_i(load), .count_i(count),
		.ft_i(fall_through_mode_i), .storage_empty_n_i(storage_empty_n_o),
		.out_ready_n_i(out_ready_n_o), .rd_data_i(rd_data_o),
		.rd_en_n_o(rd_en_n_i), .read_select_n_o(read_select_n_i),
		.got_o(got), .got_data_o(got_data));

	initial forever #4 mclk_i = ~mclk_i;
	initial begin
		#3;
		forever #32 rd_clk_i = ~rd_clk_i;
	end

	function automatic logic [17:0] lfsr(input logic [17:0] s);
		lfsr = {s[16:0], s[17] ^ s[10]};
	endfunction

	// expected flags from the word count: full, room, near, empty, ready
	function automatic logic [17:0] expf();
		int  n;
		logic ft;
		n = q.size();
		ft = fall_through_mode_i;
		expf = {13'h0000, !(!ft && n == cap), !ft || n == cap,
			n < cap - M, !ft && n != 0, !ft || n == 0};
	endfunction

	task automatic check(input string what, input logic [17:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		if (fails == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic hit(input logic part, ft, ts);
		@(posedge mclk_i);
		if (part) begin
			partial_reset_n_i <= 1'b0;
		end else begin
			master_reset_n_i     <= 1'b0;
			fall_through_mode_i  <= ft;
			flag_timing_select_i <= ts;
			cap = ft ? 2049 : 2048;
		end
		repeat (6) @(posedge rd_clk_i);
		@(posedge mclk_i);
		master_reset_n_i  <= 1'b1;
		partial_reset_n_i <= 1'b1;
		q.delete();
		repeat (6) @(posedge rd_clk_i);
	endtask

	task automatic put(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk_i);
			wr_en_n_i <= 1'b0;
			wr_data_i <= seed;
			if (q.size() < cap)
				q.push_back(seed);
			seed = lfsr(seed);
		end
		@(posedge mclk_i);
		wr_en_n_i <= 1'b1;
	endtask

	// writes offered while the clock enable is low must not land
	task automatic freeze();
		@(posedge mclk_i);
		ce_i      <= 1'b0;
		wr_en_n_i <= 1'b0;
		wr_data_i <= seed;
		repeat (4) @(posedge mclk_i);
		wr_en_n_i <= 1'b1;
		ce_i      <= 1'b1;
	endtask

	task automatic drain(input int n);
		int t;
		t = q.size() - n;
		@(posedge rd_clk_i);
		load  <= 1'b1;
		count <= 12'(n);
		@(posedge rd_clk_i);
		load <= 1'b0;
		for (int i = 0; i < 400 && q.size() > t; i++)
			@(posedge rd_clk_i);
		if (q.size() > t) begin
			fails++;
			give_verdict();
		end
	endtask

	task automatic settle();
		repeat (12) @(posedge rd_clk_i);
		check("flags", flags, expf());
	endtask

	always @(posedge rd_clk_i) begin
		if (got) begin
			last_w = got_data;
			if (q.size() == 0)
				check("extra", got_data, ~got_data);
			else
				check("rd_data", got_data, q.pop_front());
		end
	end

	initial begin
		repeat (20) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		hit(1'b0, 1'b0, 1'b1);
		put(2048 - M - 1);
		settle();
		put(1);
		settle();
		put(M + 2);
		settle();
		drain(4);
		settle();
		hit(1'b1, 1'b0, 1'b1);
		freeze();
		settle();
		put(3);
		settle();
		drain(3);
		settle();
		check("held", rd_data_o, last_w);
		hit(1'b0, 1'b1, 1'b0);
		put(1);
		settle();
		check("shown", rd_data_o, q[0]);
		drain(1);
		settle();
		check("held", rd_data_o, last_w);
		put(2049 - M - 1);
		settle();
		put(1);
		settle();
		put(M + 1);
		settle();
		drain(20);
		settle();
		give_verdict();
	end
endmodule // dual_clock_fifo_status_flags_bench

// File: verif/fifo_flags_chk.sv
// flag timing and reset checks for the dual clock buffer
`timescale 1ns/1ps
module fifo_flags_chk (
	// clocks and resets
	input wire logic mclk_i,
	input wire logic rd_clk_i,
	input wire logic rst_b_i,
	input wire logic master_reset_n_i,
	input wire logic partial_reset_n_i,
	input wire logic fall_through_mode_i,
	// requests
	input wire logic wr_en_n_i,
	input wire logic rd_en_n_i,
	// flags
	input wire logic storage_full_n_o,
	input wire logic write_room_n_o,
	input wire logic near_full_n_o,
	input wire logic storage_empty_n_o,
	input wire logic out_ready_n_o
);
	// read edges since both reset pins went high, saturating
	logic [2:0] calm_r;
	wire        calm = calm_r == 3'h7;
	always_ff @(posedge rd_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			calm_r <= 3'h0;
		else if (!master_reset_n_i || !partial_reset_n_i)
			calm_r <= 3'h0;
		else if (!calm)
			calm_r <= calm_r + 3'h1;
	end
	room_excl_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i)
		!storage_full_n_o |-> write_room_n_o) else $error("full and room low");
	ready_excl_a: assert property (
		@(posedge rd_clk_i) disable iff (!rst_b_i)
		!out_ready_n_o |-> !storage_empty_n_o) else $error("empty and ready");
	full_timing_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i) $fell(storage_full_n_o)
		|-> !$past(wr_en_n_i, 2) || !$past(wr_en_n_i, 3))
		else $error("full fell without write");
	near_timing_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i) $fell(near_full_n_o)
		|-> !$past(wr_en_n_i) || !$past(wr_en_n_i, 2) || !$past(wr_en_n_i, 3))
		else $error("near full fell without write");
	ready_rise_a: assert property (
		@(posedge rd_clk_i) disable iff (!rst_b_i)
		$rose(out_ready_n_o) && calm |-> !$past(rd_en_n_i))
		else $error("ready rose without read");
	empty_fall_a: assert property (
		@(posedge rd_clk_i) disable iff (!rst_b_i)
		$fell(storage_empty_n_o) && calm
		|-> !$past(rd_en_n_i) || !$past(rd_en_n_i, 2) || !$past(rd_en_n_i, 3))
		else $error("empty fell without read");
	wr_reset_a: assert property (
		@(posedge mclk_i) disable iff (!rst_b_i) (!master_reset_n_i)[*8]
		|-> storage_full_n_o && near_full_n_o
		&& (write_room_n_o == !fall_through_mode_i))
		else $error("write flags not reset");
	rd_reset_a: assert property (
		@(posedge rd_clk_i) disable iff (!rst_b_i)
		(!master_reset_n_i || !partial_reset_n_i)[*5]
		|-> !storage_empty_n_o && out_ready_n_o)
		else $error("read flags not reset");
endmodule // fifo_flags_chk
bind dual_clock_fifo_status_flags fifo_flags_chk fifo_flags_chk_i (
	.mclk_i, .rd_clk_i, .rst_b_i, .master_reset_n_i, .partial_reset_n_i,
	.fall_through_mode_i,
	.wr_en_n_i, .rd_en_n_i, .storage_full_n_o, .write_room_n_o,
	.near_full_n_o, .storage_empty_n_o, .out_ready_n_o);

// File: verif/fifo_reader.sv
// reader agent that drains the buffer on the read clock
`timescale 1ns/1ps
module fifo_reader (
	// clock and reset
	input  wire logic        rd_clk_i,
	input  wire logic        rst_b_i,
	// work from the bench
	input  wire logic        load_i,
	input  wire logic [11:0] count_i,
	input  wire logic        ft_i,
	// buffer read side
	input  wire logic        storage_empty_n_i,
	input  wire logic        out_ready_n_i,
	input  wire logic [17:0] rd_data_i,
	output logic             rd_en_n_o,
	output logic             read_select_n_o,
	// words taken
	output logic             got_o,
	output logic      [17:0] got_data_o
);
	logic [11:0] left_r;
	logic [11:0] left_nxt;
	logic [1:0]  gap_r;
	logic [1:0]  pend_r;
	wire         take_ft = ft_i && !rd_en_n_o && !out_ready_n_i;
	// empty lags a read, so wait four edges before trusting it
	wire         issue = !ft_i && gap_r == 2'h0 && storage_empty_n_i
		&& left_r != 12'h000;
	assign left_nxt = load_i ? count_i : left_r - {11'h000, issue || take_ft};
	always_ff @(posedge rd_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			left_r          <= 12'h000;
			gap_r           <= 2'h0;
			pend_r          <= 2'h0;
			rd_en_n_o       <= 1'b1;
			read_select_n_o <= 1'b1;
			got_o           <= 1'b0;
			got_data_o      <= 18'h00000;
		end else begin
			left_r          <= left_nxt;
			gap_r           <= issue ? 2'h3 : gap_r - {1'b0, gap_r != 2'h0};
			pend_r          <= {pend_r[0], issue};
			rd_en_n_o       <= ft_i ? left_nxt == 12'h000 : !issue;
			read_select_n_o <= left_nxt == 12'h000 && !issue;
			got_o           <= take_ft || pend_r[1];
			got_data_o      <= rd_data_i;
		end
	end
endmodule // fifo_reader
